// ===== hdl/lcd_channel.sv
// one line channel: drive monitor, transmit gating, attenuator fifo, pattern test and loopbacks
//
// The APB register port and the placing of the registers are this design's own decisions.
`default_nettype none
module lcd_channel
	import lcd_pkg::*;
#(
	parameter int unsigned IDLE_PERIODS = DM_IDLE_PERIODS,
	parameter int unsigned ACQ_BITS = PRBS_ACQ_BITS,
	parameter int unsigned LOSS_ERRS = PRBS_LOSS_ERRS
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// system side
	input wire logic transmit_clock_in,
	input wire logic transmit_data_pos_in,
	input wire logic transmit_data_neg_in,
	output logic receive_clock_out,
	output logic receive_data_pos_out,
	output logic rx_neg_or_violation_out,
	// line side
	input wire logic transmitter_enable_pin,
	input wire logic line_recv_clock_in,
	input wire logic line_recv_pos_in,
	input wire logic line_recv_neg_in,
	input wire logic monitor_line_pos_in,
	input wire logic monitor_line_neg_in,
	output logic line_drive_pos_out,
	output logic line_drive_neg_out,
	output logic line_drive_oe,
	output logic drive_fault_flag_out
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int P_TXC = 0;
	localparam int P_TXP = 1;
	localparam int P_TXN = 2;
	localparam int P_RXC = 3;
	localparam int P_RXP = 4;
	localparam int P_RXN = 5;
	localparam int P_MNP = 6;
	localparam int P_MNN = 7;
	localparam int P_TXE = 8;
	localparam int NPIN = 9;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1;
	logic [NPIN-1:0] pin_s2;
	logic [NPIN-1:0] pin_s3;
	logic [NPIN-1:0] pin_f;
	logic [NPIN-1:0] next_pin_f;

	assign pin_raw = {transmitter_enable_pin, monitor_line_neg_in, monitor_line_pos_in, line_recv_neg_in,
		line_recv_pos_in, line_recv_clock_in, transmit_data_neg_in, transmit_data_pos_in, transmit_clock_in};
	// a change is accepted only once stages two and three agree
	assign next_pin_f = (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pin_f);

	// three-stage sampling of every outside pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_f <= '0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= next_pin_f;
		end
	end

	logic txc_tick;
	logic rxc_tick;
	logic mon_toggle;
	lcd_rails_type sys_tx;
	lcd_rails_type line_rx_pin;

	assign txc_tick = next_pin_f[P_TXC] & ~pin_f[P_TXC];
	assign rxc_tick = next_pin_f[P_RXC] & ~pin_f[P_RXC];
	assign mon_toggle = (next_pin_f[P_MNP] != pin_f[P_MNP]) | (next_pin_f[P_MNN] != pin_f[P_MNN]);
	assign sys_tx = '{pos: next_pin_f[P_TXP], neg: next_pin_f[P_TXN]};
	assign line_rx_pin = '{pos: next_pin_f[P_RXP], neg: next_pin_f[P_RXN]};

	// ----------------------------------------------------------------
	// apb register file
	// ----------------------------------------------------------------
	logic [CTRL_USED_BITS-1:0] ctrl;
	logic fifo_limit_flag;
	logic pattern_sync_lost;
	logic transmitter_on;
	logic [5:0] fifo_fill;
	logic apb_wr;
	logic apb_rd;
	logic hit_ctrl;
	logic hit_stat;
	logic stat_read;
	logic [31:0] stat_word;

	assign hit_ctrl = (paddr == CTRL_OFFSET);
	assign hit_stat = (paddr == STAT_OFFSET);
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & penable & ~pwrite;
	assign stat_read = apb_rd & hit_stat;
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~(hit_ctrl | hit_stat);

	always_comb begin
		stat_word = 32'h0000_0000;
		stat_word[STAT_FIFO_LIM_POS] = fifo_limit_flag;
		stat_word[STAT_SYNC_LOST_POS] = pattern_sync_lost;
		stat_word[STAT_DRV_FAULT_POS] = drive_fault_flag_out;
		stat_word[STAT_TX_ON_POS] = transmitter_on;
		stat_word[STAT_FILL_POS +: 6] = fifo_fill;
	end

	// control writes land at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET[CTRL_USED_BITS-1:0];
		end else if (apb_wr && hit_ctrl) begin
			ctrl <= pwdata[CTRL_USED_BITS-1:0];
		end
	end

	// read data captured in the setup cycle so it leaves a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			if (hit_ctrl) begin
				prdata <= {{(32-CTRL_USED_BITS){1'b0}}, ctrl};
			end else if (hit_stat) begin
				prdata <= stat_word;
			end else begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	logic transmitter_enable_bit;
	logic attenuator_path_select;
	logic attenuator_cfg_bit0;
	logic attenuator_cfg_bit1;
	logic pattern_mode_enable;
	logic pattern_error_insert;
	logic rate_e3;
	lcd_loop_type loop_mode;

	assign transmitter_enable_bit = ctrl[CTRL_TX_EN_POS];
	assign attenuator_path_select = ctrl[CTRL_PATH_POS]; // 1 = transmit path
	assign attenuator_cfg_bit0 = ctrl[CTRL_CFG0_POS];
	assign attenuator_cfg_bit1 = ctrl[CTRL_CFG1_POS];
	assign pattern_mode_enable = ctrl[CTRL_PAT_EN_POS];
	assign pattern_error_insert = ctrl[CTRL_ERR_INS_POS];
	assign rate_e3 = ctrl[CTRL_RATE_E3_POS];
	assign loop_mode = lcd_loop_decode(ctrl[CTRL_LB_REM_POS], ctrl[CTRL_LB_LOC_POS]);

	// ----------------------------------------------------------------
	// transmit drive monitor
	// ----------------------------------------------------------------
	logic [7:0] idle_count;

	// counts transmit clock periods without a line transition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_count <= 8'h00;
			drive_fault_flag_out <= 1'b0;
		end else if (mon_toggle) begin
			idle_count <= 8'h00;
			drive_fault_flag_out <= 1'b0;
		end else if (txc_tick && !drive_fault_flag_out) begin
			if (idle_count == 8'(IDLE_PERIODS - 1)) begin
				drive_fault_flag_out <= 1'b1;
			end else begin
				idle_count <= idle_count + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmitter gating
	// ----------------------------------------------------------------
	// the register bit alone cannot keep a dead card on: pin has the final word
	assign transmitter_on = pin_f[P_TXE] & transmitter_enable_bit;

	// ----------------------------------------------------------------
	// jitter attenuator fifo
	// ----------------------------------------------------------------
	logic atten_on;
	logic path_tx;
	logic [5:0] depth;
	logic wr_tick;
	logic rd_tick;
	logic primed;
	logic fifo_clear;
	lcd_rails_type fifo_mem [0:FIFO_LARGE-1];
	lcd_rails_type fifo_in;
	lcd_rails_type fifo_q;
	logic [4:0] wptr;
	logic [4:0] rptr;
	logic [4:0] ptr_mask;
	logic tx_tick;

	assign atten_on = attenuator_cfg_bit0 ^ attenuator_cfg_bit1;
	assign depth = attenuator_cfg_bit1 ? 6'(FIFO_LARGE) : 6'(FIFO_SMALL);
	assign ptr_mask = 5'(depth - 6'd1);
	assign path_tx = attenuator_path_select;
	// remote loopback times the transmit side from the receive clock
	assign tx_tick = (loop_mode == LB_REMOTE) ? rxc_tick : txc_tick;
	assign wr_tick = atten_on & (path_tx ? tx_tick : rxc_tick);
	assign fifo_clear = ~atten_on | stat_read;

	// smoothed read clock: averages the write spacing over eight periods
	logic [15:0] gap_count;
	logic [15:0] gap_acc;
	logic [15:0] rd_count;
	logic [12:0] gap_avg;

	assign gap_avg = gap_acc[15:3];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_count <= 16'h0000;
			gap_acc <= 16'h0000;
		end else if (wr_tick) begin
			gap_count <= 16'h0001;
			gap_acc <= gap_acc - {3'b000, gap_avg} + gap_count;
		end else if (gap_count != 16'hffff) begin
			gap_count <= gap_count + 16'h0001;
		end
	end

	assign rd_tick = primed & (rd_count >= {3'b000, gap_avg});

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_count <= 16'h0000;
		end else if (rd_tick || !primed) begin
			rd_count <= 16'h0001;
		end else if (rd_count != 16'hffff) begin
			rd_count <= rd_count + 16'h0001;
		end
	end

	// pointers, fill and centring; reads start once half full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= 5'd0;
			rptr <= 5'd0;
			fifo_fill <= 6'd0;
			primed <= 1'b0;
		end else if (fifo_clear) begin
			wptr <= 5'd0;
			rptr <= 5'd0;
			fifo_fill <= 6'd0;
			primed <= 1'b0;
		end else begin
			if (wr_tick && fifo_fill != depth) begin
				wptr <= (wptr + 5'd1) & ptr_mask;
			end
			if (rd_tick && fifo_fill != 6'd0) begin
				rptr <= (rptr + 5'd1) & ptr_mask;
			end
			fifo_fill <= fifo_fill + 6'((wr_tick && fifo_fill != depth) ? 1 : 0)
				- 6'((rd_tick && fifo_fill != 6'd0) ? 1 : 0);
			if (fifo_fill >= (depth >> 1)) begin
				primed <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk) begin
		if (wr_tick) begin
			fifo_mem[wptr] <= fifo_in;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_q <= '0;
		end else if (rd_tick && fifo_fill != 6'd0) begin
			fifo_q <= fifo_mem[rptr];
		end
	end

	// limit flag: a new hit in the read cycle wins over the clear
	logic near_limit;

	assign near_limit = primed & atten_on & ((fifo_fill >= depth - 6'(FIFO_MARGIN))
		| (fifo_fill <= 6'(FIFO_MARGIN)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_limit_flag <= 1'b0;
		end else if (near_limit) begin
			fifo_limit_flag <= 1'b1;
		end else if (stat_read) begin
			fifo_limit_flag <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// data paths and loopbacks
	// ----------------------------------------------------------------
	lcd_rails_type line_out;
	lcd_rails_type rx_line;
	lcd_rails_type rx_after;
	lcd_rails_type tx_pre;
	lcd_rails_type pat_rails;
	logic ami_phase;
	logic [22:0] gen_lfsr;
	logic gen_bit;
	logic err_arm;
	logic ins_prev;

	// analog loopback: receiver sees the driven line, receive rail pins ignored, receive clock pin still used
	assign rx_line = (loop_mode == LB_ANALOG) ? line_out : line_rx_pin;
	assign rx_after = (atten_on && !path_tx) ? fifo_q : rx_line;
	assign gen_bit = lcd_prbs_fb(gen_lfsr, rate_e3) ^ err_arm;
	// single-rail pattern is ami coded onto the line rails
	assign pat_rails = gen_bit ? (ami_phase ? lcd_rails_type'{pos: 1'b0, neg: 1'b1}
		: lcd_rails_type'{pos: 1'b1, neg: 1'b0}) : lcd_rails_type'(2'b00);

	always_comb begin
		if (loop_mode == LB_REMOTE) begin
			tx_pre = rx_after;
		end else if (pattern_mode_enable) begin
			tx_pre = pat_rails;
		end else begin
			tx_pre = sys_tx;
		end
	end

	assign fifo_in = path_tx ? tx_pre : rx_line;

	// line driver register and pattern generator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_out <= '0;
			gen_lfsr <= PRBS_SEED;
			ami_phase <= 1'b0;
		end else if (tx_tick) begin
			line_out <= (atten_on && path_tx) ? fifo_q : tx_pre;
			if (pattern_mode_enable) begin
				gen_lfsr <= {gen_lfsr[21:0], lcd_prbs_fb(gen_lfsr, rate_e3)};
				ami_phase <= ami_phase ^ gen_bit;
			end
		end
	end

	// one error per 0-to-1 write; the arm beats its own consumption
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ins_prev <= 1'b0;
			err_arm <= 1'b0;
		end else begin
			ins_prev <= pattern_error_insert;
			if (pattern_mode_enable && pattern_error_insert && !ins_prev) begin
				err_arm <= 1'b1;
			end else if (tx_tick || !pattern_mode_enable) begin
				err_arm <= 1'b0;
			end
		end
	end

	// drivers released whenever the transmitter is off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_drive_pos_out <= 1'b0;
			line_drive_neg_out <= 1'b0;
			line_drive_oe <= 1'b0;
		end else begin
			line_drive_pos_out <= transmitter_on & line_out.pos;
			line_drive_neg_out <= transmitter_on & line_out.neg;
			line_drive_oe <= transmitter_on;
		end
	end

	// ----------------------------------------------------------------
	// pattern checker
	// ----------------------------------------------------------------
	lcd_chk_type chk_state;
	logic [22:0] chk_lfsr;
	logic [5:0] good_run;
	logic [3:0] err_count;
	logic rx_bit;
	logic chk_err;
	logic viol;

	assign rx_bit = rx_after.pos | rx_after.neg;
	assign chk_err = lcd_prbs_fb(chk_lfsr, rate_e3) != rx_bit;
	assign pattern_sync_lost = pattern_mode_enable & (chk_state != CHK_SYNC);

	// hunts on received bits, then flywheels so one error shows once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chk_state <= CHK_HUNT;
			chk_lfsr <= PRBS_SEED;
			good_run <= 6'd0;
			err_count <= 4'd0;
			viol <= 1'b0;
		end else if (!pattern_mode_enable) begin
			chk_state <= CHK_HUNT;
			good_run <= 6'd0;
			err_count <= 4'd0;
			viol <= 1'b0;
		end else if (rxc_tick) begin
			good_run <= chk_err ? 6'd0 : ((good_run == 6'(ACQ_BITS)) ? good_run : good_run + 6'd1);
			unique case (chk_state)
				CHK_HUNT: begin
					chk_lfsr <= {chk_lfsr[21:0], rx_bit};
					viol <= 1'b1;
					err_count <= 4'd0;
					if (!chk_err && good_run == 6'(ACQ_BITS - 1)) begin
						chk_state <= CHK_SYNC;
					end
				end
				CHK_SYNC: begin
					chk_lfsr <= {chk_lfsr[21:0], lcd_prbs_fb(chk_lfsr, rate_e3)};
					viol <= chk_err;
					if (chk_err && err_count == 4'(LOSS_ERRS - 1)) begin
						chk_state <= CHK_HUNT;
					end else if (chk_err) begin
						err_count <= err_count + 4'd1;
					end else if (good_run == 6'(ACQ_BITS)) begin
						err_count <= 4'd0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// receive outputs
	// ----------------------------------------------------------------
	logic rx_out_tick;

	assign rx_out_tick = (loop_mode == LB_DIGITAL) ? txc_tick : rxc_tick;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			receive_clock_out <= 1'b0;
			receive_data_pos_out <= 1'b0;
			rx_neg_or_violation_out <= 1'b0;
		end else begin
			receive_clock_out <= (loop_mode == LB_DIGITAL) ? pin_f[P_TXC] : pin_f[P_RXC];
			if (rx_out_tick) begin
				if (loop_mode == LB_DIGITAL) begin
					receive_data_pos_out <= sys_tx.pos;
					rx_neg_or_violation_out <= sys_tx.neg;
				end else if (pattern_mode_enable) begin
					receive_data_pos_out <= rx_bit;
					rx_neg_or_violation_out <= viol;
				end else begin
					receive_data_pos_out <= rx_after.pos;
					rx_neg_or_violation_out <= rx_after.neg;
				end
			end
		end
	end

endmodule : lcd_channel
`default_nettype wire

// ===== hdl/lcd_pkg.sv
// constants, types and decode helpers of the line channel diagnostics block
`default_nettype none
package lcd_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STAT_OFFSET = 12'h004;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// control fields
	localparam int CTRL_TX_EN_POS = 0;
	localparam int CTRL_PATH_POS = 1;
	localparam int CTRL_CFG0_POS = 2;
	localparam int CTRL_CFG1_POS = 3;
	localparam int CTRL_PAT_EN_POS = 4;
	localparam int CTRL_ERR_INS_POS = 5;
	localparam int CTRL_LB_REM_POS = 6;
	localparam int CTRL_LB_LOC_POS = 7;
	localparam int CTRL_RATE_E3_POS = 8;
	localparam int CTRL_USED_BITS = 9;
	// status fields
	localparam int STAT_FIFO_LIM_POS = 0;
	localparam int STAT_SYNC_LOST_POS = 1;
	localparam int STAT_DRV_FAULT_POS = 2;
	localparam int STAT_TX_ON_POS = 3;
	localparam int STAT_FILL_POS = 8;

	// ----------------------------------------------------------------
	// timing and sizes
	// ----------------------------------------------------------------
	localparam int unsigned DM_IDLE_PERIODS = 128;
	localparam int unsigned FIFO_SMALL = 16;
	localparam int unsigned FIFO_LARGE = 32;
	localparam int unsigned FIFO_MARGIN = 2;
	localparam int unsigned PRBS_ACQ_BITS = 32;
	localparam int unsigned PRBS_LOSS_ERRS = 4;
	localparam logic [22:0] PRBS_SEED = 23'h7f_ffff;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic pos;
		logic neg;
	} lcd_rails_type;

	typedef enum logic [3:0] {
		LB_NONE = 4'b0001,
		LB_DIGITAL = 4'b0010,
		LB_REMOTE = 4'b0100,
		LB_ANALOG = 4'b1000
	} lcd_loop_type;

	typedef enum logic [1:0] {
		CHK_HUNT = 2'b01,
		CHK_SYNC = 2'b10
	} lcd_chk_type;

	// remote/local bits: 00 none, 01 digital, 10 remote, 11 analog
	function automatic lcd_loop_type lcd_loop_decode(input logic rem, input logic loc);
		unique case ({rem, loc})
			2'b00: lcd_loop_decode = LB_NONE;
			2'b01: lcd_loop_decode = LB_DIGITAL;
			2'b10: lcd_loop_decode = LB_REMOTE;
			2'b11: lcd_loop_decode = LB_ANALOG;
		endcase
	endfunction : lcd_loop_decode

	// pattern feedback: 2^23-1 at e3, 2^15-1 otherwise
	function automatic logic lcd_prbs_fb(input logic [22:0] s, input logic e3);
		lcd_prbs_fb = e3 ? (s[22] ^ s[17]) : (s[14] ^ s[13]);
	endfunction : lcd_prbs_fb

endpackage : lcd_pkg
`default_nettype wire

// ===== verif/lcd_channel_properties.sv
// port assertions of the line channel
`default_nettype none
module lcd_channel_properties
	import lcd_pkg::*;
#(
	parameter int unsigned IDLE_PERIODS = DM_IDLE_PERIODS
) (
	// clock, reset and apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// pins
	input wire logic transmitter_enable_pin,
	input wire logic transmit_clock_in,
	input wire logic receive_clock_out,
	input wire logic monitor_line_pos_in,
	input wire logic monitor_line_neg_in,
	input wire logic line_drive_pos_out,
	input wire logic line_drive_neg_out,
	input wire logic line_drive_oe,
	input wire logic drive_fault_flag_out
);
	logic [8:0] ctrl;
	logic [4:0] age;
	logic [15:0] quiet;
	logic [1:0] mon;
	logic ok;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// shadow control; age lets the pin synchronisers settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
			age <= '0;
		end else if (psel && penable && pwrite && paddr == CTRL_OFFSET) begin
			ctrl <= pwdata[8:0];
			age <= '0;
		end else if (age != 5'd31) begin
			age <= age + 5'd1;
		end
	end
	assign ok = age == 5'd31;
	// cycles since the monitor taps last moved
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mon <= '0;
			quiet <= '0;
		end else begin
			mon <= {monitor_line_pos_in, monitor_line_neg_in};
			if (mon != {monitor_line_pos_in, monitor_line_neg_in}) begin
				quiet <= '0;
			end else if (quiet != 16'hffff) begin
				quiet <= quiet + 16'd1;
			end
		end
	end
	sequence busy_line;
		(quiet < 16'd12) [*8];
	endsequence
	sequence digital_tx_edge;
		ok && ctrl[7:6] == 2'b10 && ctrl[3] == ctrl[2] && $rose(transmit_clock_in);
	endsequence
	AST_DRIVERS_RELEASED: assert property (!line_drive_oe |-> !line_drive_pos_out && !line_drive_neg_out)
		else $error("rails driven while off");
	AST_PIN_OFF: assert property (!transmitter_enable_pin [*6] |-> !line_drive_oe)
		else $error("driving with pin low");
	AST_BIT_OFF: assert property (ok && !ctrl[CTRL_TX_EN_POS] |-> !line_drive_oe)
		else $error("driving with bit clear");
	AST_PIN_HANDOVER: assert property ((ok && ctrl[0] && transmitter_enable_pin) [*6] |-> line_drive_oe)
		else $error("pin does not switch on");
	AST_FAULT_NEEDS_QUIET: assert property ($rose(drive_fault_flag_out) |-> quiet >= (IDLE_PERIODS - 1) * 6)
		else $error("fault raised too early");
	AST_FAULT_CLEARS: assert property (drive_fault_flag_out && quiet == 16'd0 |-> ##[1:16] !drive_fault_flag_out)
		else $error("fault not cleared");
	AST_FAULT_LOW_BUSY: assert property (busy_line ##1 busy_line |-> !drive_fault_flag_out)
		else $error("fault on a busy line");
	AST_DIGITAL_CLOCK: assert property (digital_tx_edge |-> ##[2:8] $rose(receive_clock_out))
		else $error("tx clock not looped");
endmodule : lcd_channel_properties
bind lcd_channel lcd_channel_properties #(.IDLE_PERIODS(IDLE_PERIODS)) u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .transmitter_enable_pin, .transmit_clock_in, .receive_clock_out, .monitor_line_pos_in,
	.monitor_line_neg_in, .line_drive_pos_out, .line_drive_neg_out, .line_drive_oe, .drive_fault_flag_out);
`default_nettype wire

// ===== verif/lcd_framer_model.sv
// behavioural framer on the far side: line clocks and rails
`default_nettype none
module lcd_framer_model
	import lcd_pkg::*;
(
	// bench controls
	input wire logic rx_run,
	input wire logic toggle,
	input wire lcd_rails_type tx_val,
	input wire lcd_rails_type rx_val,
	// system transmit side
	output logic tx_clk,
	output lcd_rails_type tx_rails,
	// line receive side
	output logic rx_clk,
	output lcd_rails_type rx_rails
);
	timeunit 1ns;
	timeprecision 100ps;
	logic flip = 1'b0;
	// tx clock free running; rx clock stalls to starve a fifo
	initial begin
		tx_clk = 1'b0;
		forever #40 tx_clk = ~tx_clk;
	end
	initial begin
		rx_clk = 1'b0;
		#13;
		forever #40 rx_clk = rx_run ? ~rx_clk : 1'b0;
	end
	// rails move on the falling edge, half a bit before sampling
	always @(negedge tx_clk) begin
		flip <= ~flip;
	end
	assign tx_rails = tx_val ^ {2{toggle & flip}};
	assign rx_rails = rx_val;
endmodule : lcd_framer_model
`default_nettype wire

// ===== verif/line_channel_diagnostics_test.sv
// self-checking bench of one line channel
`default_nettype none
module line_channel_diagnostics_test
	import lcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned IDLE = 8;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdata, cw;
	logic pin, rx_run, toggle, tclk, rclk, rxc, rxp, rxv, ldp, ldn, ldoe, fault;
	lcd_rails_type tx_val, rx_val, txr, rxr;
	int mismatches = 0;
	int n_tests = 0;
	int n, h;
	lcd_framer_model far (.rx_run(rx_run), .toggle(toggle), .tx_val(tx_val), .rx_val(rx_val), .tx_clk(tclk),
		.tx_rails(txr), .rx_clk(rclk), .rx_rails(rxr));
	// monitor taps wired back to the line rails, as on a board
	lcd_channel #(.IDLE_PERIODS(IDLE)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.transmit_clock_in(tclk), .transmit_data_pos_in(txr.pos), .transmit_data_neg_in(txr.neg),
		.receive_clock_out(rxc), .receive_data_pos_out(rxp), .rx_neg_or_violation_out(rxv),
		.transmitter_enable_pin(pin), .line_recv_clock_in(rclk), .line_recv_pos_in(rxr.pos),
		.line_recv_neg_in(rxr.neg), .monitor_line_pos_in(ldp), .monitor_line_neg_in(ldn),
		.line_drive_pos_out(ldp), .line_drive_neg_out(ldn), .line_drive_oe(ldoe), .drive_fault_flag_out(fault));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic results();
		$display("mismatches %0d comparisons %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// one apb transfer, pready awaited under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 1, 32'(i < 16));
		if (i == 16) results();
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		apb(1'b0, a, '0);
		chk(s, e, rdata & m);
	endtask : rd
	// bounded wait on the fault flag or the violation pin
	task automatic wait_for(input bit sel, input logic v, input int lim);
		for (n = 0; n < lim; n++) begin
			@(posedge pclk);
			if ((sel ? rxv : fault) === v) break;
		end
		chk("wait", 1, 32'(n < lim));
		if (n == lim) results();
	endtask : wait_for
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pin = 1'b0;
		rx_run = 1'b1;
		toggle = 1'b1;
		tx_val = 2'b10;
		rx_val = 2'b01;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, field width, unmapped place
		rd(CTRL_OFFSET, '1, CTRL_RESET, "ctrl reset");
		rd(STAT_OFFSET, 32'h9, 32'h0, "stat reset");
		apb(1'b1, CTRL_OFFSET, 32'hffff_ffff);
		apb(1'b1, 12'h008, 32'h0000_0000);
		rd(CTRL_OFFSET, '1, 32'h0000_01ff, "ctrl");
		rd(12'h008, '1, 32'h0, "unmapped");
		chk("pslverr", 1, 32'(err));
		// transmitter needs both pin and bit
		for (int i = 0; i < 4; i++) begin
			pin <= i[1];
			apb(1'b1, CTRL_OFFSET, 32'(i & 1));
			repeat (12) @(posedge pclk);
			chk("oe", 32'(i == 3), 32'(ldoe));
			rd(STAT_OFFSET, 32'h8, (i == 3) ? 32'h8 : 32'h0, "tx on");
			if (i != 3) chk("rails off", 0, {ldp, ldn});
		end
		// drive monitor on a busy, then a silent line
		repeat (40) @(posedge pclk);
		chk("fault busy", 0, 32'(fault));
		pin <= 1'b0;
		wait_for(1'b0, 1'b1, 200);
		chk("fault delay", 1, 32'(n >= (IDLE - 1) * 8 && n <= (IDLE + 3) * 8));
		pin <= 1'b1;
		wait_for(1'b0, 1'b0, 40);
		// steady rails show which side reaches which output
		toggle <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, CTRL_OFFSET, 32'h1 | 32'((m >> 1) << CTRL_LB_REM_POS) | 32'((m & 1) << CTRL_LB_LOC_POS));
			repeat (60) @(posedge pclk);
			chk("rx out", m[0] ? tx_val : rx_val, {rxp, rxv});
			chk("line out", (m == 2) ? rx_val : tx_val, {ldp, ldn});
		end
		// pattern through the analog loop at both rates
		for (int r = 0; r < 2; r++) begin
			cw = 32'h0000_00d1 | 32'(r << CTRL_RATE_E3_POS);
			// park the checker with the violation pin low, so hunting shows as a rise
			apb(1'b1, CTRL_OFFSET, 32'h0000_00c1);
			repeat (20) @(posedge pclk);
			apb(1'b1, CTRL_OFFSET, cw);
			wait_for(1'b1, 1'b1, 100);
			wait_for(1'b1, 1'b0, 3000);
			rd(STAT_OFFSET, 32'h2, 32'h0, "sync lost");
			for (int e = 0; e < 2; e++) begin
				apb(1'b1, CTRL_OFFSET, cw);
				apb(1'b1, CTRL_OFFSET, cw | 32'h20);
				h = 0;
				repeat (400) begin
					@(posedge pclk);
					if (rxv === 1'b1) h++;
				end
				chk("one error pulse", 1, 32'(h >= 7 && h <= 9));
			end
		end
		// steady line rails never match the pattern
		apb(1'b1, CTRL_OFFSET, 32'h0000_0011);
		repeat (600) @(posedge pclk);
		rd(STAT_OFFSET, 32'h2, 32'h2, "sync lost");
		chk("violation", 1, 32'(rxv));
		chk("single rail", 1, 32'(rxp));
		// starve the small receive fifo, then read to clear
		apb(1'b1, CTRL_OFFSET, 32'h0000_0005);
		repeat (400) @(posedge pclk);
		rx_run <= 1'b0;
		repeat (400) @(posedge pclk);
		rd(STAT_OFFSET, 32'h1, 32'h1, "fifo limit");
		// a near-empty hit in that read cycle outlives it; the emptied fifo cannot hit again
		rd(STAT_OFFSET, 32'h3f00, 32'h0, "fifo emptied");
		rd(STAT_OFFSET, 32'h1, 32'h0, "fifo cleared");
		rx_run <= 1'b1;
		results();
	end
endmodule : line_channel_diagnostics_test
`default_nettype wire
